/* verilog/tbtx_pkg.sv */
// Constants, types and helpers for the token bus media and transmit handshake node.
package tbtx_pkg;
	localparam int CLK_NS = 4;
	localparam int UNIT_NS = 3200;
	localparam int MARK_NS = 1600;
	localparam int PRESC_FULL = 64;
	localparam int PRESC_HALF = 128;
	localparam int RESP_NS = 597600;
	localparam int IDLE_NS = 656000;
	localparam int RESP_CYC_DEF = RESP_NS / CLK_NS;
	localparam int IDLE_CYC_DEF = IDLE_NS / CLK_NS;
	localparam int TMR_W = 11;
	localparam int TMO_W = 19;
	localparam logic [TMR_W-1:0] UNIT_CYC = TMR_W'(UNIT_NS / CLK_NS);
	localparam logic [TMR_W-1:0] MARK_CYC = TMR_W'(MARK_NS / CLK_NS);
	localparam logic [TMR_W-1:0] BCLK_CYC = TMR_W'(MARK_NS / CLK_NS / 2);
	localparam int RATE_MUL = PRESC_HALF / PRESC_FULL;
	localparam logic [3:0] ALERT_UNITS = 4'h6;
	localparam logic [3:0] CHAR_UNITS = 4'hb;
	localparam logic [3:0] SPACE_IDX = 4'h2;
	localparam logic [3:0] DATA_IDX = 4'h3;
	localparam logic [7:0] CH_ENQ = 8'h85;
	localparam logic [7:0] CH_EOT = 8'h04;
	localparam logic [7:0] CH_SOH = 8'h01;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_NAK = 8'h15;
	localparam logic [8:0] ADDR_CHARS = 9'h003;
	localparam logic [8:0] REPLY_CHARS = 9'h001;
	localparam logic [8:0] PKT_OVH = 9'h007;
	localparam logic [8:0] PKT_DATA0 = 9'h005;
	localparam logic [8:0] PKT_CNT = 9'h004;
	localparam logic [8:0] PAGE_LEN = 9'h100;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	typedef enum logic [1:0] {FR_ENQ, FR_ITT, FR_PKT, FR_RSP} tbtx_frame_t;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ENQ = 7'h02,
		ST_WENQ = 7'h04,
		ST_PKT = 7'h08,
		ST_WACK = 7'h10,
		ST_PASS = 7'h20,
		ST_REPLY = 7'h40
	} tbtx_state_t;
	// Length counts data bytes, 1 to 256.
	typedef struct packed {
		logic [7:0] dest;
		logic [8:0] len;
	} tbtx_cmd_t;
	typedef struct packed {
		logic rx_ok;
		logic tx_acked;
		logic tx_done;
	} tbtx_stat_t;

	// Reflected check update, low bit first, so a frame with its check appended leaves zero.
	function automatic logic [15:0] tbtx_crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

/* verilog/tbtx_node.sv */
// Media interface and transmit handshake of a token-passing network node.
`timescale 1ns/1ps
module tbtx_node #(
	parameter int RESP_CYC = tbtx_pkg::RESP_CYC_DEF,
	parameter int IDLE_CYC = tbtx_pkg::IDLE_CYC_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic backplane,
	input wire logic open_drain_sel,
	input wire logic rate_half,
	input wire logic [7:0] my_id,
	input wire logic [7:0] next_id,
	input wire logic rx_enable,
	input wire logic tx_cmd_valid,
	input wire tbtx_pkg::tbtx_cmd_t tx_cmd,
	output logic tx_cmd_ready,
	input wire logic tx_data_valid,
	input wire logic [7:0] tx_data,
	output logic tx_data_ready,
	input wire tbtx_pkg::tbtx_stat_t stat_clear,
	input wire tbtx_pkg::tbtx_stat_t int_mask,
	output tbtx_pkg::tbtx_stat_t status,
	output logic interrupt,
	output logic idle_line,
	output logic line_pulse_out_a_n,
	output logic line_pulse_out_a_oe,
	input wire logic line_pulse_out_b_in,
	output logic line_pulse_out_b_n,
	output logic line_pulse_out_b_oe,
	input wire logic line_receive_in,
	output logic transmit_driver_enable
);
	// ==========================================================
	// Rate selection
	// ==========================================================
	wire [tbtx_pkg::TMR_W-1:0] unit_len = rate_half ?
		tbtx_pkg::TMR_W'(tbtx_pkg::UNIT_CYC * tbtx_pkg::RATE_MUL) : tbtx_pkg::UNIT_CYC;
	wire [tbtx_pkg::TMR_W-1:0] mark_len = rate_half ?
		tbtx_pkg::TMR_W'(tbtx_pkg::MARK_CYC * tbtx_pkg::RATE_MUL) : tbtx_pkg::MARK_CYC;
	wire [tbtx_pkg::TMR_W-1:0] bclk_len = rate_half ?
		tbtx_pkg::TMR_W'(tbtx_pkg::BCLK_CYC * tbtx_pkg::RATE_MUL) : tbtx_pkg::BCLK_CYC;
	wire [tbtx_pkg::TMO_W-1:0] resp_len = rate_half ?
		tbtx_pkg::TMO_W'(RESP_CYC * tbtx_pkg::RATE_MUL) : tbtx_pkg::TMO_W'(RESP_CYC);
	wire [tbtx_pkg::TMO_W-1:0] idle_len = rate_half ?
		tbtx_pkg::TMO_W'(IDLE_CYC * tbtx_pkg::RATE_MUL) : tbtx_pkg::TMO_W'(IDLE_CYC);

	// ==========================================================
	// Two-entry transmit data buffer
	// ==========================================================
	logic [7:0] buf_r [2];
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic pop;
	wire push = tx_data_valid && tx_data_ready;
	wire buf_v = cnt_r != 2'h0;
	assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
	wire [1:0] wr_idx = cnt_r - {1'b0, pop};
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_r <= 2'h0;
			tx_data_ready <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tx_data_ready <= cnt_nxt != tbtx_pkg::BUF_DEPTH;
		end
		if (pop) begin
			buf_r[0] <= buf_r[1];
		end
		if (push) begin
			buf_r[wr_idx[0]] <= tx_data;
		end
	end

	// ==========================================================
	// Transmit serializer
	// ==========================================================
	tbtx_pkg::tbtx_frame_t kind_r;
	tbtx_pkg::tbtx_cmd_t cmd_r;
	logic go_r, busy_r, alert_r, bit_r, done_r;
	logic [tbtx_pkg::TMR_W-1:0] ut_r;
	logic [3:0] uidx_r;
	logic [8:0] chi_r;
	logic [7:0] char_r, code_r, dest_r, nxt_char;
	logic [15:0] crc_r;
	wire [8:0] n_chars = kind_r == tbtx_pkg::FR_PKT ? cmd_r.len + tbtx_pkg::PKT_OVH :
		kind_r == tbtx_pkg::FR_RSP ? tbtx_pkg::REPLY_CHARS : tbtx_pkg::ADDR_CHARS;
	wire unit_end = busy_r && ut_r == unit_len - 1'b1;
	wire last_u = alert_r ? uidx_r == tbtx_pkg::ALERT_UNITS - 1'b1 :
		uidx_r == tbtx_pkg::CHAR_UNITS - 1'b1;
	wire last_ch = !alert_r && chi_r == n_chars - 1'b1;
	wire [8:0] chi_nxt = alert_r ? 9'h000 : chi_r + 9'h001;
	wire [8:0] crc_at = cmd_r.len + tbtx_pkg::PKT_DATA0;
	wire in_data = kind_r == tbtx_pkg::FR_PKT && chi_nxt >= tbtx_pkg::PKT_DATA0 &&
		chi_nxt < crc_at;
	wire ld_want = unit_end && last_u && !last_ch;
	wire stall = ld_want && in_data && !buf_v;
	wire ld = ld_want && !stall;
	assign pop = ld && in_data;
	wire [3:0] uidx_nx = uidx_r + 4'h1;
	wire [3:0] bsel = uidx_nx - tbtx_pkg::DATA_IDX;
	wire nb = uidx_nx < tbtx_pkg::SPACE_IDX ? 1'b1 :
		uidx_nx == tbtx_pkg::SPACE_IDX ? 1'b0 : char_r[bsel[2:0]];

	// Enquiry and token frames share layout: code, then the address twice.
	always_comb begin
		nxt_char = dest_r;
		if (chi_nxt == 9'h000) begin
			nxt_char = code_r;
		end else if (kind_r == tbtx_pkg::FR_PKT) begin
			if (chi_nxt == 9'h001) begin
				nxt_char = my_id;
			end else if (chi_nxt == tbtx_pkg::PKT_CNT) begin
				nxt_char = 8'(tbtx_pkg::PAGE_LEN - cmd_r.len);
			end else if (in_data) begin
				nxt_char = buf_r[0];
			end else if (chi_nxt == crc_at) begin
				nxt_char = crc_r[7:0];
			end else if (chi_nxt > crc_at) begin
				nxt_char = crc_r[15:8];
			end
		end
	end

	always_ff @(posedge clock) begin
		done_r <= 1'b0;
		if (rst) begin
			busy_r <= 1'b0;
			bit_r <= 1'b0;
		end else if (go_r) begin
			busy_r <= 1'b1;
			alert_r <= 1'b1;
			uidx_r <= 4'h0;
			chi_r <= 9'h000;
			ut_r <= '0;
			bit_r <= 1'b1;
			crc_r <= tbtx_pkg::CRC_INIT;
		end else if (stall) begin
			bit_r <= 1'b0;
		end else if (unit_end) begin
			ut_r <= '0;
			if (ld) begin
				alert_r <= 1'b0;
				uidx_r <= 4'h0;
				chi_r <= chi_nxt;
				char_r <= nxt_char;
				bit_r <= 1'b1;
				if (chi_nxt != 9'h000 && chi_nxt < crc_at) begin
					crc_r <= tbtx_pkg::tbtx_crc_byte(crc_r, nxt_char);
				end
			end else if (last_u) begin
				busy_r <= 1'b0;
				bit_r <= 1'b0;
				done_r <= 1'b1;
			end else begin
				uidx_r <= uidx_nx;
				bit_r <= alert_r | nb;
			end
		end else if (busy_r) begin
			ut_r <= ut_r + 1'b1;
		end
	end

	// ==========================================================
	// Line pins and driver enable
	// ==========================================================
	logic strap_done_r, act_high_r, bclk_r;
	logic [tbtx_pkg::TMR_W-1:0] bt_r;
	wire mark_a = busy_r && bit_r && ut_r < mark_len;
	wire mark_b = busy_r && bit_r && ut_r >= mark_len;
	always_ff @(posedge clock) begin
		if (rst) begin
			strap_done_r <= 1'b0;
			act_high_r <= 1'b0;
			bt_r <= '0;
			bclk_r <= 1'b1;
			line_pulse_out_a_n <= 1'b1;
			line_pulse_out_a_oe <= 1'b0;
			line_pulse_out_b_n <= 1'b1;
			line_pulse_out_b_oe <= 1'b0;
			transmit_driver_enable <= 1'b0;
		end else begin
			if (!strap_done_r) begin
				strap_done_r <= 1'b1;
				act_high_r <= backplane && !line_pulse_out_b_in;
			end
			bt_r <= bt_r == bclk_len - 1'b1 ? '0 : bt_r + 1'b1;
			if (bt_r == bclk_len - 1'b1) begin
				bclk_r <= !bclk_r;
			end
			line_pulse_out_a_n <= !mark_a;
			line_pulse_out_a_oe <= !(backplane && open_drain_sel) || mark_a;
			line_pulse_out_b_n <= backplane ? bclk_r : !mark_b;
			line_pulse_out_b_oe <= strap_done_r;
			transmit_driver_enable <= strap_done_r && (busy_r ~^ act_high_r);
		end
	end

	// ==========================================================
	// Receive character decoder
	// ==========================================================
	logic rbusy_r, ralert_r, seen_r, rv_r, reof_r;
	logic [tbtx_pkg::TMR_W-1:0] rut_r;
	logic [3:0] ruidx_r;
	logic [7:0] rsh_r;
	wire rx_in = line_receive_in && !busy_r;
	// The edge that closes a unit already sees the first sample of the next unit, so only
	// the samples gathered before it decide the unit's value.
	wire rbit = seen_r;
	wire r_end = rbusy_r && rut_r == unit_len - 1'b1;
	wire r_bad = ralert_r ? !rbit : (ruidx_r < tbtx_pkg::SPACE_IDX && !rbit) ||
		(ruidx_r == tbtx_pkg::SPACE_IDX && rbit);
	always_ff @(posedge clock) begin
		rv_r <= 1'b0;
		reof_r <= 1'b0;
		if (rst) begin
			rbusy_r <= 1'b0;
		end else if (!rbusy_r) begin
			rbusy_r <= rx_in;
			ralert_r <= 1'b1;
			ruidx_r <= 4'h0;
			rut_r <= '0;
			seen_r <= 1'b0;
		end else if (r_end) begin
			rut_r <= '0;
			seen_r <= 1'b0;
			if (r_bad) begin
				rbusy_r <= 1'b0;
				reof_r <= 1'b1;
			end else if (ralert_r && ruidx_r == tbtx_pkg::ALERT_UNITS - 1'b1) begin
				ralert_r <= 1'b0;
				ruidx_r <= 4'h0;
			end else if (!ralert_r && ruidx_r == tbtx_pkg::CHAR_UNITS - 1'b1) begin
				ruidx_r <= 4'h0;
				rv_r <= 1'b1;
				rsh_r <= {rbit, rsh_r[7:1]};
			end else begin
				ruidx_r <= ruidx_r + 4'h1;
				if (ruidx_r >= tbtx_pkg::DATA_IDX) begin
					rsh_r <= {rbit, rsh_r[7:1]};
				end
			end
		end else begin
			rut_r <= rut_r + 1'b1;
			seen_r <= seen_r || rx_in;
		end
	end

	// ==========================================================
	// Receive frame checker
	// ==========================================================
	logic [7:0] ptype_r;
	logic [8:0] pchi_r, plen_r;
	logic [15:0] pcrc_r;
	logic pidok_r, ev_ack_r, ev_nak_r, ev_enq_r, ev_tok_r, ev_pkt_r;
	wire is_soh = ptype_r == tbtx_pkg::CH_SOH;
	wire id_pos = is_soh ? (pchi_r == 9'h002 || pchi_r == 9'h003) :
		(pchi_r == 9'h001 || pchi_r == 9'h002);
	wire one = pchi_r == tbtx_pkg::REPLY_CHARS;
	wire addr_ok = pchi_r == tbtx_pkg::ADDR_CHARS && pidok_r;
	always_ff @(posedge clock) begin
		ev_ack_r <= reof_r && one && ptype_r == tbtx_pkg::CH_ACK;
		ev_nak_r <= reof_r && one && ptype_r == tbtx_pkg::CH_NAK;
		ev_enq_r <= reof_r && addr_ok && ptype_r == tbtx_pkg::CH_ENQ;
		ev_tok_r <= reof_r && addr_ok && ptype_r == tbtx_pkg::CH_EOT;
		ev_pkt_r <= reof_r && is_soh && pidok_r && pcrc_r == 16'h0000 &&
			pchi_r == plen_r + tbtx_pkg::PKT_OVH;
		if (rst || reof_r) begin
			pchi_r <= 9'h000;
			pidok_r <= 1'b1;
			pcrc_r <= tbtx_pkg::CRC_INIT;
			plen_r <= 9'h000;
			ptype_r <= 8'h00;
		end else if (rv_r) begin
			pchi_r <= pchi_r + 9'h001;
			if (pchi_r == 9'h000) begin
				ptype_r <= rsh_r;
			end else begin
				pcrc_r <= tbtx_pkg::tbtx_crc_byte(pcrc_r, rsh_r);
			end
			if (id_pos && rsh_r != my_id) begin
				pidok_r <= 1'b0;
			end
			if (is_soh && pchi_r == tbtx_pkg::PKT_CNT) begin
				plen_r <= tbtx_pkg::PAGE_LEN - {1'b0, rsh_r};
			end
		end
	end

	// ==========================================================
	// Token handshake sequencer and status
	// ==========================================================
	tbtx_pkg::tbtx_state_t st_r;
	logic pend_r;
	logic [tbtx_pkg::TMO_W-1:0] tmo_r;
	logic [tbtx_pkg::TMO_W-1:0] idle_cnt_r;
	tbtx_pkg::tbtx_stat_t set_s;
	wire tmo_hit = tmo_r == '0;
	wire [2:0] stat_nxt = (status & ~stat_clear) | set_s; // set wins over a clear
	assign set_s = '{rx_ok: ev_pkt_r,
		tx_acked: st_r == tbtx_pkg::ST_WACK && ev_ack_r,
		tx_done: st_r == tbtx_pkg::ST_WACK && (ev_ack_r || tmo_hit)};
	always_ff @(posedge clock) begin
		go_r <= 1'b0;
		tmo_r <= tmo_hit ? tmo_r : tmo_r - 1'b1;
		if (rst) begin
			st_r <= tbtx_pkg::ST_IDLE;
			pend_r <= 1'b0;
			tx_cmd_ready <= 1'b0;
			status <= '0;
			interrupt <= 1'b0;
			tmo_r <= '0;
			kind_r <= tbtx_pkg::FR_ITT;
		end else begin
			status <= stat_nxt;
			interrupt <= |(stat_nxt & int_mask);
			tx_cmd_ready <= !pend_r && !(tx_cmd_valid && tx_cmd_ready);
			if (tx_cmd_valid && tx_cmd_ready) begin
				pend_r <= 1'b1;
				cmd_r <= tx_cmd;
			end
			unique case (st_r)
				tbtx_pkg::ST_IDLE: begin
					if (ev_tok_r) begin
						go_r <= 1'b1;
						kind_r <= pend_r ? tbtx_pkg::FR_ENQ : tbtx_pkg::FR_ITT;
						code_r <= pend_r ? tbtx_pkg::CH_ENQ : tbtx_pkg::CH_EOT;
						dest_r <= pend_r ? cmd_r.dest : next_id;
						st_r <= pend_r ? tbtx_pkg::ST_ENQ : tbtx_pkg::ST_PASS;
					end else if (ev_enq_r || ev_pkt_r) begin
						go_r <= 1'b1;
						kind_r <= tbtx_pkg::FR_RSP;
						code_r <= ev_pkt_r || rx_enable ? tbtx_pkg::CH_ACK :
							tbtx_pkg::CH_NAK;
						st_r <= tbtx_pkg::ST_REPLY;
					end
				end
				tbtx_pkg::ST_ENQ, tbtx_pkg::ST_PKT: begin
					if (done_r) begin
						tmo_r <= resp_len;
						st_r <= st_r == tbtx_pkg::ST_ENQ ? tbtx_pkg::ST_WENQ :
							tbtx_pkg::ST_WACK;
					end
				end
				tbtx_pkg::ST_WENQ: begin
					if (ev_ack_r) begin
						go_r <= 1'b1;
						kind_r <= tbtx_pkg::FR_PKT;
						code_r <= tbtx_pkg::CH_SOH;
						st_r <= tbtx_pkg::ST_PKT;
					end else if (ev_nak_r || tmo_hit) begin
						go_r <= 1'b1;
						kind_r <= tbtx_pkg::FR_ITT;
						code_r <= tbtx_pkg::CH_EOT;
						dest_r <= next_id;
						st_r <= tbtx_pkg::ST_PASS;
					end
				end
				tbtx_pkg::ST_WACK: begin
					if (ev_ack_r || tmo_hit) begin
						pend_r <= 1'b0;
						go_r <= 1'b1;
						kind_r <= tbtx_pkg::FR_ITT;
						code_r <= tbtx_pkg::CH_EOT;
						dest_r <= next_id;
						st_r <= tbtx_pkg::ST_PASS;
					end
				end
				tbtx_pkg::ST_PASS, tbtx_pkg::ST_REPLY: begin
					if (done_r) begin
						st_r <= tbtx_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Line is reported idle once no activity was seen for the scaled idle time.
	always_ff @(posedge clock) begin
		if (rst || rbusy_r || busy_r || line_receive_in) begin
			idle_cnt_r <= '0;
			idle_line <= 1'b0;
		end else if (idle_cnt_r != idle_len) begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end else begin
			idle_line <= 1'b1;
		end
	end
endmodule

/* sim/tbtx_node_props.sv */
// Checker of the node's pin, status and handshake behaviour.
`timescale 1ns/1ps
module tbtx_node_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic backplane,
	input wire logic rate_half,
	input wire logic tx_cmd_valid,
	input wire logic tx_cmd_ready,
	input wire tbtx_pkg::tbtx_stat_t stat_clear,
	input wire tbtx_pkg::tbtx_stat_t int_mask,
	input wire tbtx_pkg::tbtx_stat_t status,
	input wire logic interrupt,
	input wire logic line_pulse_out_a_n,
	input wire logic line_pulse_out_a_oe,
	input wire logic line_pulse_out_b_n,
	input wire logic line_pulse_out_b_oe,
	input wire logic transmit_driver_enable
);
	// ==========================================
	// Helper logic
	logic [10:0] low_cnt_r;
	wire logic [10:0] mark_len = tbtx_pkg::MARK_CYC << rate_half;
	always_ff @(posedge clock) begin
		if (rst || line_pulse_out_a_n) begin
			low_cnt_r <= 11'h000;
		end else begin
			low_cnt_r <= low_cnt_r + 11'h001;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// ==========================================
	// Assertions
	a_reset_pins_quiet: assert property ($fell(rst) |-> line_pulse_out_a_n &&
		!line_pulse_out_a_oe && line_pulse_out_b_n && 3'(status) == 3'h0 && !interrupt)
		else $error("pins or status not quiet after reset");
	a_strap_then_drive: assert property ($fell(rst) |->
		!line_pulse_out_b_oe ##[1:2] line_pulse_out_b_oe)
		else $error("pin b drive not enabled after strap sample");
	a_irq_from_mask: assert property (interrupt == |(3'(status) & 3'($past(int_mask))))
		else $error("interrupt does not match masked status");
	a_status_sticky: assert property (
		(3'($past(status)) & ~3'(status) & ~3'($past(stat_clear))) == 3'h0)
		else $error("status bit fell without clear");
	a_pulses_apart: assert property (!backplane |-> line_pulse_out_a_n || line_pulse_out_b_n)
		else $error("both pulse outputs low together");
	a_b_follows_a: assert property ($rose(line_pulse_out_a_n) && !backplane |->
		!line_pulse_out_b_n)
		else $error("second pulse does not follow first");
	a_mark_width: assert property ($rose(line_pulse_out_a_n) |-> low_cnt_r == mark_len)
		else $error("mark pulse width wrong");
	a_txen_low_active: assert property (!line_pulse_out_a_n && !backplane |->
		!transmit_driver_enable)
		else $error("driver enable not active during mark");
	a_cmd_taken_once: assert property (tx_cmd_valid && tx_cmd_ready |=> !tx_cmd_ready)
		else $error("command ready stays high after take");
endmodule
bind tbtx_node tbtx_node_props i_tbtx_node_props (.clock, .rst, .backplane, .rate_half,
	.tx_cmd_valid, .tx_cmd_ready, .stat_clear, .int_mask, .status, .interrupt,
	.line_pulse_out_a_n, .line_pulse_out_a_oe, .line_pulse_out_b_n, .line_pulse_out_b_oe,
	.transmit_driver_enable);

/* sim/tbtx_far_node.sv */
// Model of a far node seen through its line transceiver.
`timescale 1ns/1ps
module tbtx_far_node (
	input wire logic clock,
	input wire logic rate_half,
	input wire logic line_pulse_out_a_n,
	output logic line_receive_in
);
	logic [7:0] rx_chars [0:2];
	logic frame_ok;
	initial line_receive_in = 1'b0;
	function automatic int unit_len();
		return int'(tbtx_pkg::UNIT_CYC) * (rate_half ? tbtx_pkg::RATE_MUL : 1);
	endfunction
	// A mark is a pulse in the first half of the unit, a space leaves the line quiet.
	task automatic send_unit(input logic mark);
		line_receive_in <= mark;
		repeat (unit_len() / 2) @(posedge clock);
		line_receive_in <= 1'b0;
		repeat (unit_len() / 2) @(posedge clock);
	endtask
	task automatic send_frame(input logic [23:0] chars, input int n);
		repeat (6) send_unit(1'b1);
		for (int c = 0; c < n; c++) begin
			send_unit(1'b1);
			send_unit(1'b1);
			send_unit(1'b0);
			for (int b = 0; b < 8; b++) begin
				send_unit(chars[8 * c + b]);
			end
		end
		send_unit(1'b0);
	endtask
	// Samples the first pulse output in the middle of each mark half.
	task automatic recv_frame(input int n);
		frame_ok = 1'b1;
		while (line_pulse_out_a_n !== 1'b0) @(posedge clock);
		repeat (unit_len() / 4 + unit_len() * 6) @(posedge clock);
		for (int c = 0; c < n; c++) begin
			for (int s = 0; s < 11; s++) begin
				if (s < 3 && ((line_pulse_out_a_n === 1'b0) != (s < 2))) begin
					frame_ok = 1'b0;
				end
				if (s >= 3) begin
					rx_chars[c][s - 3] = ~line_pulse_out_a_n;
				end
				repeat (unit_len()) @(posedge clock);
			end
		end
	endtask
endmodule

/* sim/tbtx_node_test.sv */
// Self-checking testbench of the node's transmit handshake.
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
	num_errors++; $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tbtx_node_test;
	logic clock, rst, backplane, open_drain_sel, rate_half, rx_enable;
	logic [7:0] my_id, next_id, dest, tx_data;
	logic tx_cmd_valid, tx_cmd_ready, tx_data_valid, tx_data_ready, interrupt, idle_line;
	tbtx_pkg::tbtx_cmd_t tx_cmd;
	tbtx_pkg::tbtx_stat_t stat_clear, int_mask, status;
	logic line_pulse_out_a_n, line_pulse_out_a_oe, line_pulse_out_b_n, line_pulse_out_b_oe;
	logic line_receive_in, transmit_driver_enable;
	logic [7:0] bytes [0:1];
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int gap;
	int toggles = 0;
	logic prev_b;
	// Pin b floats high through its pull-up when released, which straps an active-low enable.
	wire logic pin_b = line_pulse_out_b_oe ? line_pulse_out_b_n : 1'b1;
	// The response limit must outlast the far node's reply frame, or a reply is never seen.
	tbtx_node #(.RESP_CYC(20000), .IDLE_CYC(1000)) i_tbtx_node (.clock(clock), .rst(rst),
		.backplane(backplane), .open_drain_sel(open_drain_sel), .rate_half(rate_half),
		.my_id(my_id), .next_id(next_id), .rx_enable(rx_enable),
		.tx_cmd_valid(tx_cmd_valid), .tx_cmd(tx_cmd), .tx_cmd_ready(tx_cmd_ready),
		.tx_data_valid(tx_data_valid), .tx_data(tx_data), .tx_data_ready(tx_data_ready),
		.stat_clear(stat_clear), .int_mask(int_mask), .status(status), .interrupt(interrupt),
		.idle_line(idle_line), .line_pulse_out_a_n(line_pulse_out_a_n),
		.line_pulse_out_a_oe(line_pulse_out_a_oe), .line_pulse_out_b_in(pin_b),
		.line_pulse_out_b_n(line_pulse_out_b_n), .line_pulse_out_b_oe(line_pulse_out_b_oe),
		.line_receive_in(line_receive_in), .transmit_driver_enable(transmit_driver_enable));
	tbtx_far_node i_tbtx_far_node (.clock(clock), .rate_half(rate_half),
		.line_pulse_out_a_n(line_pulse_out_a_n), .line_receive_in(line_receive_in));
	// ==========================================
	// Clock, watchdog and verdict
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 118000) begin
			num_errors++;
			finish_test();
		end
	end
	task finish_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		rst = 1'b1;
		backplane = 1'b0;
		rate_half = 1'b0;
		tx_cmd_valid = 1'b0;
		tx_data_valid = 1'b0;
		tx_data = 8'h00;
		tx_cmd = '0;
		stat_clear = '0;
		void'($urandom(81));
		open_drain_sel = 1'($urandom());
		rx_enable = 1'($urandom());
		int_mask = 3'($urandom());
		my_id = 8'h01 + 8'($urandom_range(0, 99));
		next_id = my_id + 8'h01 + 8'($urandom_range(0, 49));
		dest = my_id + 8'h33 + 8'($urandom_range(0, 49));
		bytes[0] = 8'($urandom());
		bytes[1] = 8'hff;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		`CHECK("cmd ready", 1'b1, tx_cmd_ready)
		`CHECK("status", 3'h0, status)
		tx_cmd_valid <= 1'b1;
		tx_cmd <= '{dest: dest, len: 9'h002};
		do @(posedge clock); while (tx_cmd_ready !== 1'b1);
		tx_cmd_valid <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			tx_data <= bytes[i];
			tx_data_valid <= 1'b1;
			do @(posedge clock); while (tx_data_ready !== 1'b1);
		end
		tx_data_valid <= 1'b0;
		stat_clear <= 3'($urandom());
		repeat (2) @(posedge clock);
		stat_clear <= '0;
		`CHECK("buffer full", 1'b0, tx_data_ready)
		`CHECK("cmd pending", 1'b0, tx_cmd_ready)
		i_tbtx_far_node.send_frame({my_id, my_id, tbtx_pkg::CH_EOT}, 3);
		i_tbtx_far_node.recv_frame(3);
		`CHECK("enq framing", 1'b1, i_tbtx_far_node.frame_ok)
		`CHECK("enq code", tbtx_pkg::CH_ENQ, i_tbtx_far_node.rx_chars[0])
		`CHECK("enq dest", dest, i_tbtx_far_node.rx_chars[1])
		`CHECK("enq dest again", dest, i_tbtx_far_node.rx_chars[2])
		gap = 16 + $urandom_range(0, 300);
		repeat (gap) @(posedge clock);
		i_tbtx_far_node.send_frame({16'h0000, tbtx_pkg::CH_NAK}, 1);
		repeat (8) @(posedge clock);
		`CHECK("pass after nak", 1'b0, transmit_driver_enable)
		i_tbtx_far_node.recv_frame(3);
		`CHECK("pass code", tbtx_pkg::CH_EOT, i_tbtx_far_node.rx_chars[0])
		`CHECK("pass id", next_id, i_tbtx_far_node.rx_chars[1])
		`CHECK("pass id again", next_id, i_tbtx_far_node.rx_chars[2])
		`CHECK("still pending", 1'b0, tx_cmd_ready)
		`CHECK("no delivery", 3'h0, status)
		repeat (600) @(posedge clock);
		`CHECK("line not yet idle", 1'b0, idle_line)
		repeat (800) @(posedge clock);
		`CHECK("idle line", 1'b1, idle_line)
		backplane <= 1'b1;
		repeat (4) @(posedge clock);
		`CHECK("pin a drive", !open_drain_sel, line_pulse_out_a_oe)
		prev_b = line_pulse_out_b_n;
		repeat (1600) begin
			@(posedge clock);
			toggles += int'(line_pulse_out_b_n !== prev_b);
			prev_b = line_pulse_out_b_n;
		end
		`CHECK("bus clock edges", 4 * 1600 / int'(tbtx_pkg::UNIT_CYC), toggles)
		finish_test();
	end
endmodule
